/* File: verilog/return_exec.sv */
/*
 * execution of the three return instructions: pops the call stack into
 * the program counter, loads the accumulator for the literal form and
 * sets the global interrupt enable for the interrupt form. each takes two
 * instruction cycles: the second flushes the prefetched word.
 * assumes clk is the instruction-cycle clock and the stack answers its
 * top entry combinationally on stack_top_entry.
 */
`timescale 1ns/10ps
// Function
// - interrupt return pops stack into program counter
// - interrupt return sets global interrupt enable bit
// - interrupt return: one word, two cycles
// - literal return loads immediate into accumulator
// - literal return pops stack, two cycles
// - subroutine return pops stack, keeps interrupt enable
module return_exec #(
	parameter int pc_width = return_pkg::pc_width_default
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [13:0] instr,
	input wire logic instr_valid,
	input wire logic [pc_width-1:0] stack_top_entry,
	input wire logic interrupt_taken,
	output logic [pc_width-1:0] pc_load_value,
	output logic pc_load,
	output logic stack_pop,
	output logic [7:0] accumulator,
	output logic global_interrupt_enable,
	output logic flush_cycle,
	output logic busy,
	output logic status_write
);
	// decoder results for the word on instr
	return_pkg::return_kind_type kind;
	logic [7:0] literal;
	// execution state and the next values of the output registers except status_write
	return_pkg::exec_state_type state, next_state;
	logic [pc_width-1:0] next_pc_load_value;
	logic next_pc_load, next_stack_pop, next_global_interrupt_enable;
	logic next_flush_cycle, next_busy;
	logic [7:0] next_accumulator;
	// cycles spent in the current return, read only by its own increment and the checks below
	logic [1:0] cycle_count, next_cycle_count;

	// refuse program counter widths the stack port cannot serve
	if (pc_width < 8 || pc_width > 16) begin : gen_width_check
		$error("pc_width must be 8 to 16");
	end

	return_decode decoder (
		.instr(instr),
		.instr_valid(instr_valid),
		.kind(kind),
		.literal(literal)
	);

	// decode in fetch state, then spend one flush cycle
	always_comb begin
		next_state = state;
		next_pc_load_value = pc_load_value;
		next_pc_load = 1'b0;
		next_stack_pop = 1'b0;
		next_accumulator = accumulator;
		next_global_interrupt_enable = global_interrupt_enable;
		next_flush_cycle = 1'b0;
		next_busy = 1'b0;
		next_cycle_count = 2'd0;
		// entry clears first, so a same-cycle interrupt return still wins
		if (interrupt_taken) begin
			next_global_interrupt_enable = 1'b0; // hardware clears on entry
		end
		unique case (state)
			return_pkg::st_fetch: begin
				// a return word: pop, load pc and mark the first cycle busy
				if (kind != return_pkg::kind_none) begin
					next_stack_pop = 1'b1;
					next_pc_load = 1'b1;
					next_pc_load_value = stack_top_entry;
					next_busy = 1'b1;
					next_cycle_count = 2'd1;
					next_state = return_pkg::st_flush;
					if (kind == return_pkg::kind_literal) begin
						next_accumulator = literal;
					end
					if (kind == return_pkg::kind_interrupt) begin
						next_global_interrupt_enable = 1'b1;
					end
				end
			end
			return_pkg::st_flush: begin
				// second cycle: the prefetched word is dropped, its decoded kind ignored
				next_flush_cycle = 1'b1;
				next_cycle_count = cycle_count + 2'd1;
				next_state = return_pkg::st_fetch;
			end
			return_pkg::st_hold: begin
				// never entered; falls back to fetch
				next_state = return_pkg::st_fetch;
			end
			default: begin
				next_state = return_pkg::st_fetch;
			end
		endcase
	end

	// registers
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= return_pkg::st_fetch;
			pc_load_value <= '0;
			pc_load <= 1'b0;
			stack_pop <= 1'b0;
			accumulator <= return_pkg::accumulator_reset;
			global_interrupt_enable <= return_pkg::global_enable_reset;
			flush_cycle <= 1'b0;
			busy <= 1'b0;
			cycle_count <= 2'd0;
			status_write <= 1'b0;
		end else begin
			state <= next_state;
			pc_load_value <= next_pc_load_value;
			pc_load <= next_pc_load;
			stack_pop <= next_stack_pop;
			accumulator <= next_accumulator;
			global_interrupt_enable <= next_global_interrupt_enable;
			flush_cycle <= next_flush_cycle;
			busy <= next_busy;
			cycle_count <= next_cycle_count;
			status_write <= 1'b0;
		end
	end

	// pop and pc load come together, followed by the flush cycle
	chk_pop_loads_pc: assert property (@(posedge clk) disable iff (rst)
		stack_pop |-> pc_load ##1 flush_cycle)
		else $error("pop without pc load and flush");

	// a non-return word leaves the stack and the pc alone
	chk_pop_needs_return: assert property (@(posedge clk) disable iff (rst)
		(state == return_pkg::st_fetch && kind == return_pkg::kind_none)
		|=> !stack_pop && !pc_load)
		else $error("pop without a return word");

	// one pop per return
	chk_pop_one_cycle: assert property (@(posedge clk) disable iff (rst)
		stack_pop |=> !stack_pop)
		else $error("stack popped twice");

	// interrupt return sets the enable, even against a same-cycle entry
	chk_interrupt_sets_enable: assert property (@(posedge clk) disable iff (rst)
		(state == return_pkg::st_fetch && kind == return_pkg::kind_interrupt)
		|=> global_interrupt_enable)
		else $error("interrupt return did not set enable");

	// interrupt entry outside an interrupt return clears the enable
	chk_entry_clears_enable: assert property (@(posedge clk) disable iff (rst)
		(interrupt_taken && !(state == return_pkg::st_fetch
		&& kind == return_pkg::kind_interrupt)) |=> !global_interrupt_enable)
		else $error("interrupt entry did not clear enable");

	// busy for one cycle, then the flush cycle closes the count
	chk_two_cycles: assert property (@(posedge clk) disable iff (rst)
		$rose(busy) |=> !busy && flush_cycle && cycle_count == return_pkg::return_cycles)
		else $error("return did not take two cycles");

	// busy never stretches past the first cycle
	chk_busy_one_cycle: assert property (@(posedge clk) disable iff (rst)
		busy |=> !busy)
		else $error("busy held too long");

	// the pc load is a single pulse
	chk_load_one_cycle: assert property (@(posedge clk) disable iff (rst)
		pc_load |=> !pc_load)
		else $error("pc load held too long");

	// the flush cycle is a single pulse
	chk_flush_one_cycle: assert property (@(posedge clk) disable iff (rst)
		flush_cycle |=> !flush_cycle)
		else $error("flush held too long");

	// a word offered during the flush cycle is dropped
	chk_flush_refuses: assert property (@(posedge clk) disable iff (rst)
		(state == return_pkg::st_flush) |=> !busy && !pc_load && !stack_pop)
		else $error("word taken in flush cycle");

	// the immediate lands in the accumulator
	chk_literal_loaded: assert property (@(posedge clk) disable iff (rst)
		(state == return_pkg::st_fetch && kind == return_pkg::kind_literal)
		|=> accumulator == $past(literal))
		else $error("literal not loaded");

	// the load value is the stack top seen at the taking edge
	chk_pc_from_stack: assert property (@(posedge clk) disable iff (rst)
		(state == return_pkg::st_fetch && kind != return_pkg::kind_none)
		|=> pc_load_value == $past(stack_top_entry))
		else $error("pc not loaded from stack top");

	// busy, pop and load always travel together
	chk_busy_with_pop: assert property (@(posedge clk) disable iff (rst)
		busy |-> stack_pop && pc_load)
		else $error("busy without pop and load");

	// the load value holds between returns
	chk_pc_value_held: assert property (@(posedge clk) disable iff (rst)
		!pc_load |-> $stable(pc_load_value))
		else $error("pc load value changed without a load");

	// a plain return leaves the enable alone
	chk_subroutine_keeps: assert property (@(posedge clk) disable iff (rst)
		(state == return_pkg::st_fetch && kind == return_pkg::kind_subroutine
		&& !interrupt_taken) |=> $stable(global_interrupt_enable))
		else $error("subroutine return changed enable");

	// returns without a literal leave the accumulator alone
	chk_accumulator_kept: assert property (@(posedge clk) disable iff (rst)
		(state == return_pkg::st_fetch && (kind == return_pkg::kind_interrupt
		|| kind == return_pkg::kind_subroutine)) |=> $stable(accumulator))
		else $error("accumulator changed by plain return");

	// a literal return leaves the enable alone
	chk_literal_keeps_enable: assert property (@(posedge clk) disable iff (rst)
		(state == return_pkg::st_fetch && kind == return_pkg::kind_literal
		&& !interrupt_taken) |=> $stable(global_interrupt_enable))
		else $error("literal return changed enable");

	// only a literal return ever writes the accumulator
	chk_acc_only_literal: assert property (@(posedge clk) disable iff (rst)
		!(state == return_pkg::st_fetch && kind == return_pkg::kind_literal)
		|=> $stable(accumulator))
		else $error("accumulator written outside a literal return");

	// no status write during a return
	chk_no_status: assert property (@(posedge clk) disable iff (rst)
		busy |-> !status_write)
		else $error("status written by return");
endmodule

/* File: verilog/return_pkg.sv */
/*
 * constants for the return-instruction execution block: opcodes, masks,
 * widths, reset values and cycle counts.
 * assumes a 14-bit instruction word and a 13-bit program counter.
 */
package return_pkg;
	localparam int instr_width = 14;
	localparam int pc_width_default = 13;
	localparam int data_width = 8;
	// opcode patterns and their compare masks
	localparam logic [13:0] op_interrupt_return = 14'h0009;
	localparam logic [13:0] op_subroutine_return = 14'h0008;
	localparam logic [13:0] op_literal_return = 14'h3400;
	localparam logic [13:0] mask_full = 14'h3fff;
	localparam logic [13:0] mask_literal = 14'h3c00;
	// immediate field position
	localparam int literal_lsb = 0;
	// enable bit position inside the interrupt control register
	localparam int enable_bit_pos = 7;
	// instruction cycles each return takes
	localparam int return_cycles = 2;
	// reset values
	localparam logic [7:0] accumulator_reset = 8'h00;
	localparam logic global_enable_reset = 1'b0;

	typedef enum logic [2:0] {
		st_fetch = 3'b001,
		st_flush = 3'b010,
		st_hold = 3'b100
	} exec_state_type;

	typedef enum logic [1:0] {
		kind_none = 2'h0,
		kind_interrupt = 2'h1,
		kind_literal = 2'h2,
		kind_subroutine = 2'h3
	} return_kind_type;
endpackage

/* File: verilog/return_decode.sv */
/*
 * combinational opcode classifier for the three return instructions.
 * assumes the instruction word is stable while instr_valid is high.
 */
`timescale 1ns/10ps
module return_decode (
	input wire logic [13:0] instr,
	input wire logic instr_valid,
	output return_pkg::return_kind_type kind,
	output logic [7:0] literal
);
	// match a word against a pattern under a mask
	function automatic logic op_match(input logic [13:0] word, input logic [13:0] pat,
		input logic [13:0] mask);
		op_match = ((word & mask) == pat);
	endfunction

	// classify; the literal form ignores its two don't-care bits
	always_comb begin
		kind = return_pkg::kind_none;
		if (instr_valid) begin
			if (op_match(instr, return_pkg::op_interrupt_return, return_pkg::mask_full)) begin
				kind = return_pkg::kind_interrupt;
			end else if (op_match(instr, return_pkg::op_subroutine_return,
				return_pkg::mask_full)) begin
				kind = return_pkg::kind_subroutine;
			end else if (op_match(instr, return_pkg::op_literal_return,
				return_pkg::mask_literal)) begin
				kind = return_pkg::kind_literal;
			end
		end
	end

	assign literal = instr[return_pkg::literal_lsb +: 8];
endmodule

/* File: bench/return_instruction_execution_tb_top.sv */
/*
 * self-checking bench for return_exec: literal, interrupt and subroutine
 * returns, back-to-back words, enable clearing and non-return words.
 * assumes the default 13-bit program counter and a 200 MHz clock.
 */
`timescale 1ns/10ps
module return_instruction_execution_tb_top;
	logic clk, rst, instr_valid, interrupt_taken;
	logic [13:0] instr;
	logic [12:0] stack_top_entry, pc_load_value;
	logic pc_load, stack_pop, global_interrupt_enable, flush_cycle, busy, status_write;
	logic [7:0] accumulator;
	int failures, cmp_count;

	return_exec dut_u (.clk(clk), .rst(rst), .instr(instr), .instr_valid(instr_valid),
		.stack_top_entry(stack_top_entry), .interrupt_taken(interrupt_taken),
		.pc_load_value(pc_load_value), .pc_load(pc_load), .stack_pop(stack_pop),
		.accumulator(accumulator), .global_interrupt_enable(global_interrupt_enable),
		.flush_cycle(flush_cycle), .busy(busy), .status_write(status_write));

	// 5 ns clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// compare single flags
	task automatic chk_bit(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: flag %b expected %b", $time, got, exp);
		end
	endtask

	// compare multi-bit values
	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: value %h expected %h", $time, got, exp);
		end
	endtask

	// present one word for one edge, settle after the taking edge
	task automatic issue(input logic [13:0] w, input logic [12:0] top);
		@(posedge clk);
		instr <= w;
		instr_valid <= 1'b1;
		stack_top_entry <= top;
		@(posedge clk);
		instr_valid <= 1'b0;
		#1;
	endtask

	// first execute cycle of a taken return
	task automatic chk_taken(input logic [12:0] top, input logic [7:0] acc, input logic en);
		chk_bit(pc_load, 1'b1);
		chk_bit(stack_pop, 1'b1);
		chk_bit(busy, 1'b1);
		chk_val({3'h0, pc_load_value}, {3'h0, top});
		chk_val({8'h0, accumulator}, {8'h0, acc});
		chk_bit(global_interrupt_enable, en);
		chk_bit(status_write, 1'b0);
		@(posedge clk);
		#1;
		chk_bit(flush_cycle, 1'b1);
		chk_bit(pc_load, 1'b0);
		chk_bit(stack_pop, 1'b0);
	endtask

	task automatic t_literal();
		issue(14'h37ff, 13'h1abc);
		chk_taken(13'h1abc, 8'hff, 1'b0);
		issue(14'h3655, 13'h0001);
		chk_taken(13'h0001, 8'h55, 1'b0);
		$display("test literal done");
	endtask

	// set wins over a same-cycle interrupt entry, then a plain interrupt return
	task automatic t_interrupt();
		@(posedge clk);
		instr <= 14'h0009;
		instr_valid <= 1'b1;
		stack_top_entry <= 13'h0321;
		interrupt_taken <= 1'b1;
		@(posedge clk);
		instr_valid <= 1'b0;
		interrupt_taken <= 1'b0;
		#1;
		chk_taken(13'h0321, 8'h55, 1'b1);
		issue(14'h0009, 13'h0123);
		chk_taken(13'h0123, 8'h55, 1'b1);
		$display("test interrupt done");
	endtask

	// enable kept by a plain return, cleared by interrupt entry
	task automatic t_subroutine();
		issue(14'h0008, 13'h0456);
		chk_taken(13'h0456, 8'h55, 1'b1);
		@(posedge clk);
		interrupt_taken <= 1'b1;
		@(posedge clk);
		interrupt_taken <= 1'b0;
		#1;
		chk_bit(global_interrupt_enable, 1'b0);
		issue(14'h0008, 13'h0789);
		chk_taken(13'h0789, 8'h55, 1'b0);
		$display("test subroutine done");
	endtask

	// second word lands in the flush cycle and is dropped
	task automatic t_back2back();
		issue(14'h0008, 13'h0aaa);
		instr <= 14'h0009;
		instr_valid <= 1'b1;
		stack_top_entry <= 13'h0555;
		chk_taken(13'h0aaa, 8'h55, 1'b0);
		instr_valid <= 1'b0;
		@(posedge clk);
		#1;
		chk_bit(pc_load, 1'b0);
		chk_bit(global_interrupt_enable, 1'b0);
		chk_val({3'h0, pc_load_value}, 16'h0aaa);
		$display("test back2back done");
	endtask

	// near-miss opcodes and an invalid word are ignored
	task automatic t_ignored();
		issue(14'h000a, 13'h0111);
		chk_bit(pc_load, 1'b0);
		issue(14'h3800, 13'h0111);
		chk_bit(pc_load, 1'b0);
		@(posedge clk);
		instr <= 14'h0009;
		@(posedge clk);
		#1;
		chk_bit(pc_load, 1'b0);
		chk_bit(global_interrupt_enable, 1'b0);
		$display("test ignored done");
	endtask

	// print counts and verdict, end the run
	task automatic results();
		$display("comparisons %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// watchdog
	initial begin
		repeat (2000) @(posedge clk);
		failures++;
		results();
	end

	// main sequence
	initial begin
		rst = 1'b1;
		instr_valid = 1'b0;
		interrupt_taken = 1'b0;
		instr = 14'h0000;
		stack_top_entry = 13'h0000;
		failures = 0;
		cmp_count = 0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk_val({8'h0, accumulator}, 16'h0000);
		chk_bit(global_interrupt_enable, 1'b0);
		chk_bit(pc_load, 1'b0);
		t_literal();
		t_interrupt();
		t_subroutine();
		t_back2back();
		t_ignored();
		results();
	end
endmodule
